// ===== rtda_pkg.sv
// shared constants and types for the rx/tx dma arbiter and its request source
package rtda_pkg;

    // ****************************************
    // arbiter configuration
    // ****************************************
    localparam int unsigned BUS_MODE_W = 32;
    localparam int unsigned BUS_MODE_ARB_BIT = 1;
    localparam int unsigned BURST_BEATS = 8;

    // ****************************************
    // arbiter states, gray along idle -> tx -> rx
    // ****************************************
    typedef enum logic [1:0] {
        RTDA_ST_IDLE = 2'b00,
        RTDA_ST_TX = 2'b01,
        RTDA_ST_RX = 2'b11
    } rtda_state_t;

    // ****************************************
    // request source register map (byte offsets)
    // ****************************************
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;

    // command bits: descriptor or setup work per process
    localparam int unsigned CMD_TX_WORK = 0;
    localparam int unsigned CMD_RX_WORK = 1;

    // status bits
    localparam int unsigned ST_TX_PEND = 0;
    localparam int unsigned ST_RX_PEND = 1;
    localparam int unsigned ST_TX_REQ = 2;
    localparam int unsigned ST_RX_REQ = 3;
    localparam int unsigned ST_TX_GNT = 4;
    localparam int unsigned ST_RX_GNT = 5;
    localparam int unsigned ST_BUSY = 6;

    // count register fields
    localparam int unsigned CNT_TX_LSB = 0;
    localparam int unsigned CNT_RX_LSB = 16;
    localparam int unsigned CNT_W = 16;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// ===== rtda_if.sv
// link between the dma arbiter and the transmit/receive request source
`timescale 1ns/10ps
interface rtda_if;
    logic tx_req;
    logic rx_req;
    logic tx_active;
    logic rx_fifo_free_low;
    logic tx_fifo_fill_low;
    logic xfer_done;
    logic pkt_end;
    logic tx_grant;
    logic rx_grant;

    modport arb (
        input tx_req,
        input rx_req,
        input tx_active,
        input rx_fifo_free_low,
        input tx_fifo_fill_low,
        input xfer_done,
        input pkt_end,
        output tx_grant,
        output rx_grant
    );

    modport src (
        output tx_req,
        output rx_req,
        output tx_active,
        output rx_fifo_free_low,
        output tx_fifo_fill_low,
        output xfer_done,
        output pkt_end,
        input tx_grant,
        input rx_grant
    );
endinterface

// ===== rtda_ahb_slave.sv
// zero-wait ahb-lite slave front end: write strobe in data phase, registered read
`timescale 1ns/10ps
module rtda_ahb_slave (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [7:0] rd_addr_o,
    input wire logic [31:0] rd_data_i,
    output logic wr_en_o,
    output logic [7:0] wr_addr_o,
    output logic [31:0] wr_data_o
);
    logic take;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;

    // only whole-word transfers are served; others complete with no effect
    assign take = hsel_i && hready_i && htrans_i[1] && (hsize_i == 3'h2);
    assign rd_addr_o = haddr_i[7:0];
    assign wr_en_o = wr_pend_q;
    assign wr_addr_o = wr_addr_q;
    assign wr_data_o = hwdata_i;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= take && hwrite_i;
            if (take) begin
                wr_addr_q <= haddr_i[7:0];
            end
        end
    end

    // read data is sampled at the address phase so it stands in the data phase
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hrdata_o <= rtda_pkg::RESET_WORD;
        end else if (take && !hwrite_i) begin
            hrdata_o <= rd_data_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end
endmodule

// ===== rtda_source.sv
// transmit and receive dma request source with an ahb-lite command port
`timescale 1ns/10ps
module rtda_source #(
    parameter int unsigned BEATS = rtda_pkg::BURST_BEATS
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    rtda_if.src link,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic tx_fifo_room_i,
    input wire logic tx_pkt_last_i,
    input wire logic tx_line_busy_i,
    input wire logic tx_fill_low_i,
    input wire logic rx_fifo_burst_i,
    input wire logic rx_fifo_eop_i,
    input wire logic rx_free_low_i
);
    initial begin
        if (BEATS < 1 || BEATS > 255) begin
            $error("BEATS out of range");
        end
    end

    logic tx_pend_q, rx_pend_q, tx_req_q, rx_req_q, done_q, pend_q;
    logic act_q, rfl_q, tfl_q;
    logic [7:0] beat_q;
    logic [15:0] tx_cnt_q, rx_cnt_q;
    logic [7:0] rd_addr, wr_addr;
    logic [31:0] rd_data, wr_data;
    logic wr_en, gnt, last_beat;

    rtda_ahb_slave u_bus (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data)
    );

    assign gnt = link.tx_grant || link.rx_grant;
    assign last_beat = gnt && !done_q && (beat_q == 8'(BEATS - 1));

    always_comb begin
        rd_data = rtda_pkg::RESET_WORD;
        case (rd_addr)
            rtda_pkg::REG_STATUS: begin
                rd_data[rtda_pkg::ST_TX_PEND] = tx_pend_q;
                rd_data[rtda_pkg::ST_RX_PEND] = rx_pend_q;
                rd_data[rtda_pkg::ST_TX_REQ] = tx_req_q;
                rd_data[rtda_pkg::ST_RX_REQ] = rx_req_q;
                rd_data[rtda_pkg::ST_TX_GNT] = link.tx_grant;
                rd_data[rtda_pkg::ST_RX_GNT] = link.rx_grant;
                rd_data[rtda_pkg::ST_BUSY] = gnt;
            end
            rtda_pkg::REG_COUNT: begin
                rd_data[rtda_pkg::CNT_TX_LSB +: rtda_pkg::CNT_W] = tx_cnt_q;
                rd_data[rtda_pkg::CNT_RX_LSB +: rtda_pkg::CNT_W] = rx_cnt_q;
            end
            default: rd_data = rtda_pkg::RESET_WORD;
        endcase
    end

    // descriptor work pending; a new command wins over completion
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_pend_q <= 1'b0;
            rx_pend_q <= 1'b0;
        end else begin
            if (wr_en && wr_addr == rtda_pkg::REG_CMD && wr_data[rtda_pkg::CMD_TX_WORK]) begin
                tx_pend_q <= 1'b1;
            end else if (last_beat && link.tx_grant) begin
                tx_pend_q <= 1'b0;
            end
            if (wr_en && wr_addr == rtda_pkg::REG_CMD && wr_data[rtda_pkg::CMD_RX_WORK]) begin
                rx_pend_q <= 1'b1;
            end else if (last_beat && link.rx_grant) begin
                rx_pend_q <= 1'b0;
            end
        end
    end

    // the granted request drops while its burst runs and the other holds; both are resampled after it completes
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_req_q <= 1'b0;
            rx_req_q <= 1'b0;
        end else if (gnt || done_q) begin
            tx_req_q <= tx_req_q && !link.tx_grant;
            rx_req_q <= rx_req_q && !link.rx_grant;
        end else begin
            tx_req_q <= tx_pend_q || tx_fifo_room_i;
            rx_req_q <= rx_pend_q || rx_fifo_burst_i || rx_fifo_eop_i;
        end
    end

    // burst beat counter; done pulses in the cycle after the last beat
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            beat_q <= 8'h00;
            done_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            done_q <= last_beat;
            if (!gnt || done_q) begin
                beat_q <= 8'h00;
            end else if (!last_beat) begin
                beat_q <= beat_q + 8'h01;
            end
            if (last_beat) begin
                pend_q <= link.tx_grant ? (tx_pkt_last_i && !tx_pend_q)
                                        : (rx_fifo_eop_i && !rx_pend_q);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_cnt_q <= 16'h0000;
            rx_cnt_q <= 16'h0000;
        end else if (last_beat) begin
            tx_cnt_q <= tx_cnt_q + {15'h0000, link.tx_grant};
            rx_cnt_q <= rx_cnt_q + {15'h0000, link.rx_grant};
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            act_q <= 1'b0;
            rfl_q <= 1'b0;
            tfl_q <= 1'b0;
        end else begin
            act_q <= tx_line_busy_i;
            rfl_q <= rx_free_low_i;
            tfl_q <= tx_fill_low_i;
        end
    end

    assign link.tx_req = tx_req_q;
    assign link.rx_req = rx_req_q;
    assign link.tx_active = act_q;
    assign link.rx_fifo_free_low = rfl_q;
    assign link.tx_fifo_fill_low = tfl_q;
    assign link.xfer_done = done_q;
    assign link.pkt_end = pend_q;
endmodule

// ===== rtda_arbiter.sv
// dma arbiter choosing transmit or receive process for the next burst
//
// Summary of operation
// - bus mode bit 1 selects receive-priority table
// - idle grants none; lone request wins; rx first
// - tx active: rx only if rx low, tx not
// - half duplex, all flags set: grant transmit
// - full duplex, all flags set: round robin
// - transmit gets a burst between rx packets
// - receive gets a burst between tx packets
// - tx requests for descriptors and setup packets
// - tx data request only with burst space
// - rx requests for descriptor fetch or close
// - rx data request on full burst or eop
// - tx active held while frame on line
//
// Chosen here: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module rtda_arbiter #(
    parameter int unsigned MODE_W = rtda_pkg::BUS_MODE_W
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    rtda_if.arb link,
    input wire logic [MODE_W-1:0] bus_mode_register_i,
    input wire logic full_duplex_i,
    output logic [1:0] arb_state_o,
    output logic tx_owed_o,
    output logic rx_owed_o,
    output logic last_rx_o
);
    // ****************************************
    // elaboration checks
    // ****************************************
    initial begin
        if (MODE_W <= rtda_pkg::BUS_MODE_ARB_BIT) begin
            $error("MODE_W too narrow for the arbitration bit");
        end
    end

    // ****************************************
    // state
    // ****************************************
    rtda_pkg::rtda_state_t state_q;
    rtda_pkg::rtda_state_t state_d;
    logic tx_grant_q;
    logic rx_grant_q;
    logic last_rx_q;
    logic tx_owed_q;
    logic rx_owed_q;
    logic rx_pri;
    logic pick_rx;
    logic any_req;
    logic burst_end;
    logic rx_pkt_end;
    logic tx_pkt_end;

    assign rx_pri = bus_mode_register_i[rtda_pkg::BUS_MODE_ARB_BIT];
    assign any_req = link.tx_req || link.rx_req;
    assign burst_end = link.xfer_done && (state_q != rtda_pkg::RTDA_ST_IDLE);
    assign rx_pkt_end = burst_end && link.pkt_end && (state_q == rtda_pkg::RTDA_ST_RX);
    assign tx_pkt_end = burst_end && link.pkt_end && (state_q == rtda_pkg::RTDA_ST_TX);

    // ****************************************
    // decision
    // ****************************************
    // returns 1 when the receive process wins the next burst
    function automatic logic choose_rx(
        input logic txr,
        input logic rxr,
        input logic act,
        input logic rfl,
        input logic tfl,
        input logic pri,
        input logic fdx,
        input logic last_rx,
        input logic tx_owe,
        input logic rx_owe
    );
        logic r;
        r = 1'b0;
        if (!rxr) begin
            r = 1'b0;
        end else if (!txr) begin
            r = 1'b1;
        end else if (tx_owe && !rx_owe) begin
            r = 1'b0;
        end else if (rx_owe && !tx_owe) begin
            r = 1'b1;
        end else if (!pri || tx_owe) begin
            // without the priority scheme, or both windows owed, simply alternate
            r = !last_rx;
        end else if (!act) begin
            r = 1'b1;
        end else if (rfl && tfl) begin
            r = fdx ? !last_rx : 1'b0;
        end else begin
            r = rfl && !tfl;
        end
        return r;
    endfunction

    always_comb begin
        pick_rx = choose_rx(link.tx_req, link.rx_req, link.tx_active,
                            link.rx_fifo_free_low, link.tx_fifo_fill_low,
                            rx_pri, full_duplex_i, last_rx_q, tx_owed_q, rx_owed_q);
    end

    // ****************************************
    // grant state machine
    // ****************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            rtda_pkg::RTDA_ST_IDLE: begin
                if (any_req) begin
                    state_d = pick_rx ? rtda_pkg::RTDA_ST_RX : rtda_pkg::RTDA_ST_TX;
                end
            end
            rtda_pkg::RTDA_ST_TX: begin
                if (link.xfer_done) begin
                    state_d = rtda_pkg::RTDA_ST_IDLE;
                end
            end
            rtda_pkg::RTDA_ST_RX: begin
                if (link.xfer_done) begin
                    state_d = rtda_pkg::RTDA_ST_IDLE;
                end
            end
            default: state_d = rtda_pkg::RTDA_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_q <= rtda_pkg::RTDA_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // grants follow the next state so they rise with the state change
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_grant_q <= 1'b0;
            rx_grant_q <= 1'b0;
        end else begin
            tx_grant_q <= (state_d == rtda_pkg::RTDA_ST_TX);
            rx_grant_q <= (state_d == rtda_pkg::RTDA_ST_RX);
        end
    end

    // remembers the last winner for alternation
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            last_rx_q <= 1'b0;
        end else if (state_q == rtda_pkg::RTDA_ST_IDLE && any_req) begin
            last_rx_q <= pick_rx;
        end
    end

    // ****************************************
    // fairness windows
    // ****************************************
    // a packet end of one process owes the other a burst; the owed flag clears
    // when that burst is granted. set and clear come from different states.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tx_owed_q <= 1'b0;
        end else if (rx_pkt_end) begin
            tx_owed_q <= 1'b1;
        end else if (state_q == rtda_pkg::RTDA_ST_IDLE && any_req && !pick_rx) begin
            tx_owed_q <= 1'b0;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rx_owed_q <= 1'b0;
        end else if (tx_pkt_end) begin
            rx_owed_q <= 1'b1;
        end else if (state_q == rtda_pkg::RTDA_ST_IDLE && any_req && pick_rx) begin
            rx_owed_q <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign link.tx_grant = tx_grant_q;
    assign link.rx_grant = rx_grant_q;
    assign arb_state_o = state_q;
    assign tx_owed_o = tx_owed_q;
    assign rx_owed_o = rx_owed_q;
    assign last_rx_o = last_rx_q;
endmodule

// ===== rtda_checker.sv
// link checker for the dma arbiter and its request source
`timescale 1ns/10ps
module rtda_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tx_req,
    input wire logic rx_req,
    input wire logic tx_active,
    input wire logic rx_fifo_free_low,
    input wire logic tx_fifo_fill_low,
    input wire logic xfer_done,
    input wire logic pkt_end,
    input wire logic tx_grant,
    input wire logic rx_grant,
    input wire logic [rtda_pkg::BUS_MODE_W-1:0] bus_mode_register_i,
    input wire logic full_duplex_i,
    input wire logic tx_owed_o,
    input wire logic rx_owed_o,
    input wire logic last_rx_o
);
    logic gnt_q;
    logic idle;
    logic both;
    logic pri;
    logic full;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gnt_q <= 1'b0;
        end else begin
            gnt_q <= tx_grant | rx_grant;
        end
    end
    // the first idle edge after a drop only serves a request left standing; it is left out
    assign idle = !tx_grant && !rx_grant && !gnt_q;
    assign both = idle && tx_req && rx_req && !tx_owed_o && !rx_owed_o;
    assign pri = bus_mode_register_i[rtda_pkg::BUS_MODE_ARB_BIT];
    assign full = both && pri && tx_active && rx_fifo_free_low && tx_fifo_fill_low;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ****************************************
    // grant checks
    // ****************************************
    AST_ONE_GRANT: assert property (!(tx_grant && rx_grant))
        else $error("both grants high");
    AST_LONE: assert property (idle && !(tx_req && rx_req) |=>
        tx_grant == $past(tx_req) && rx_grant == $past(rx_req))
        else $error("lone request not granted");
    AST_NO_LINE: assert property (both && pri && !tx_active |=> rx_grant)
        else $error("receive lost with line idle");
    AST_LINE_TABLE: assert property (both && pri && tx_active &&
        !(rx_fifo_free_low && tx_fifo_fill_low) |=> tx_grant != rx_grant &&
        rx_grant == ($past(rx_fifo_free_low) && !$past(tx_fifo_fill_low)))
        else $error("wrong choice with line active");
    AST_HALF: assert property (full && !full_duplex_i |=> tx_grant)
        else $error("half duplex did not pick transmit");
    AST_FULL_RR: assert property (full && full_duplex_i |=>
        rx_grant != $past(last_rx_o) && tx_grant == $past(last_rx_o))
        else $error("full duplex did not alternate");
    AST_NO_PRI_RR: assert property (both && !pri |=>
        rx_grant != $past(last_rx_o) && tx_grant == $past(last_rx_o))
        else $error("plain scheme did not alternate");
    AST_HOLD: assert property ((tx_grant || rx_grant) && !xfer_done |=>
        $stable(tx_grant) && $stable(rx_grant))
        else $error("grant moved mid burst");
    AST_DROP: assert property ((tx_grant || rx_grant) && xfer_done |=>
        !tx_grant && !rx_grant)
        else $error("grant held past burst end");
    AST_RX_OWES: assert property (rx_grant && xfer_done && pkt_end |=> tx_owed_o)
        else $error("transmit not owed after receive packet");
    AST_TX_OWES: assert property (tx_grant && xfer_done && pkt_end |=> rx_owed_o)
        else $error("receive not owed after transmit packet");
    AST_OWED_TX: assert property (idle && tx_req && tx_owed_o && !rx_owed_o |=> tx_grant)
        else $error("owed transmit not granted");
    AST_OWED_RX: assert property (idle && rx_req && rx_owed_o && !tx_owed_o |=> rx_grant)
        else $error("owed receive not granted");
    COV_FULL: cover property (full && full_duplex_i);
    COV_RX_PKT: cover property (rx_grant && xfer_done && pkt_end);
    COV_NO_PRI: cover property (both && !pri);
endmodule

// ===== rx_tx_dma_arbiter_tb.sv
// self-checking bench: arbiter and request source joined by their link
`timescale 1ns/10ps
module rx_tx_dma_arbiter_tb;
    // ****************************************
    // design, link and checker
    // ****************************************
    localparam int BEATS = 2;
    localparam int LIMIT = 3000;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic hsel, hwrite, hready, hresp, fdx, room, last, busy, fill, burst, eop, free;
    logic tx_owed, rx_owed, last_rx;
    logic [1:0] htrans, arb_state;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, bus_mode;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    rtda_if link();
    rtda_source #(.BEATS(BEATS)) u_rtda_source (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .link(link), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .tx_fifo_room_i(room), .tx_pkt_last_i(last),
        .tx_line_busy_i(busy), .tx_fill_low_i(fill), .rx_fifo_burst_i(burst),
        .rx_fifo_eop_i(eop), .rx_free_low_i(free));
    rtda_arbiter u_rtda_arbiter (.clock_i(clock_i), .rst_n_i(rst_n_i), .link(link),
        .bus_mode_register_i(bus_mode), .full_duplex_i(fdx), .arb_state_o(arb_state),
        .tx_owed_o(tx_owed), .rx_owed_o(rx_owed), .last_rx_o(last_rx));
    rtda_checker u_rtda_checker (.clock_i(clock_i), .rst_n_i(rst_n_i), .tx_req(link.tx_req),
        .rx_req(link.rx_req), .tx_active(link.tx_active),
        .rx_fifo_free_low(link.rx_fifo_free_low), .tx_fifo_fill_low(link.tx_fifo_fill_low),
        .xfer_done(link.xfer_done), .pkt_end(link.pkt_end), .tx_grant(link.tx_grant),
        .rx_grant(link.rx_grant), .bus_mode_register_i(bus_mode), .full_duplex_i(fdx),
        .tx_owed_o(tx_owed), .rx_owed_o(rx_owed), .last_rx_o(last_rx));
    always #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            $display("wrong value at %0t: run did not finish", $time);
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
        output logic [31:0] rd);
        @(posedge clock_i);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        htrans <= rtda_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge clock_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock_i); while (hready !== 1'b1);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    // drops the data requests at once, so a later choice starts from a clean pair
    task automatic wait_burst(output logic g);
        int n;
        n = 0;
        while (link.tx_grant !== 1'b1 && link.rx_grant !== 1'b1) @(posedge clock_i);
        g = link.rx_grant;
        check({30'h0, arb_state}, {30'h0, g ? rtda_pkg::RTDA_ST_RX : rtda_pkg::RTDA_ST_TX});
        room <= 1'b0;
        burst <= 1'b0;
        while (link.tx_grant === 1'b1 || link.rx_grant === 1'b1) begin
            if (link.xfer_done === 1'b1) begin
                last <= 1'b0;
                eop <= 1'b0;
            end
            n++;
            @(posedge clock_i);
        end
        check(n, BEATS + 1);
    endtask
    // cfg: pri, duplex, line busy, rx free low, tx fill low, tx last, rx eop
    // a tx last or rx eop case raises that side alone, so no loser burst clears the owed flag
    task automatic seq(input logic [6:0] cfg, input logic chk, input logic exp,
        output logic g);
        bus_mode <= {30'h0, cfg[6], 1'b0};
        fdx <= cfg[5];
        busy <= cfg[4];
        free <= cfg[3];
        fill <= cfg[2];
        last <= cfg[1];
        repeat (3) @(posedge clock_i);
        eop <= cfg[0];
        room <= !cfg[0];
        burst <= !cfg[1];
        @(posedge clock_i);
        wait_burst(g);
        if (chk) check({31'h0, g}, {31'h0, exp});
        repeat (8) @(posedge clock_i);
        $display("test done: cfg %b grant rx %b", cfg, g);
    endtask
    task automatic t_cmd();
        logic [31:0] rd;
        logic g;
        ahb(1'b0, rtda_pkg::REG_STATUS, 32'h0, rd);
        check(rd, rtda_pkg::RESET_WORD);
        ahb(1'b1, rtda_pkg::REG_CMD, 32'h1, rd);
        wait_burst(g);
        check({31'h0, g}, 32'h0);
        ahb(1'b1, rtda_pkg::REG_CMD, 32'h2, rd);
        wait_burst(g);
        check({31'h0, g}, 32'h1);
        ahb(1'b0, rtda_pkg::REG_STATUS, 32'h0, rd);
        check(rd, 32'h0);
        ahb(1'b0, rtda_pkg::REG_COUNT, 32'h0, rd);
        check(rd, 32'h0001_0001);
        ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
        ahb(1'b0, 8'h0c, 32'h0, rd);
        check(rd, 32'h0);
        $display("test done: command port");
    endtask
    initial begin
        logic g0;
        logic g1;
        {hsel, hwrite, fdx, room, last, busy, fill, burst, eop, free} = '0;
        {htrans, hsize, haddr, hwdata, bus_mode} = '0;
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_cmd();
        for (int c = 0; c < 8; c++) begin
            seq({2'b10, 3'(c), 2'b00}, 1'b1, !c[2] || (c[1] && !c[0]), g0);
        end
        // the loser of each pair is served next, so the following pair's winner repeats
        seq(7'b0000000, 1'b0, 1'b0, g0);
        seq(7'b0000000, 1'b1, g0, g1);
        seq(7'b0000000, 1'b1, g1, g0);
        seq(7'b1111100, 1'b0, 1'b0, g0);
        seq(7'b1111100, 1'b1, g0, g1);
        seq(7'b1111100, 1'b1, g1, g0);
        seq(7'b1000001, 1'b1, 1'b1, g0);
        seq(7'b1000000, 1'b1, 1'b0, g0);
        seq(7'b1010010, 1'b1, 1'b0, g0);
        seq(7'b1010000, 1'b1, 1'b1, g0);
        end_of_test();
    end
endmodule
